// ==== usb_pd_bmc_phy.sv ====
`timescale 1ns/100ps
// Summary of operation
// [RL1] Every bit cell starts with a line edge and a one adds a second edge at mid-cell.
// [RL2] The coded line stays near balanced, never flat longer than one bit.
// [RL3] A transmission opens by driving the line low before any coded edge.
// [RL4] The far receiver copes with losing the first edge of a frame.
// [RL5] After the final bit a closing edge lets the receiver take that bit.
// [RL6] The driver overrides the pin bias while sending and floats the pin otherwise.
// [RL7] Send and receive use only one pin of the channel pair.
// [RL8] The pin in use is fixed for the whole connection and never swapped in it.
// [RL9] A squelch output reports bus idle from the pin whoever drives it.
// [RL10] As source the comparator reference follows the advertised pull-up current.
// [RL11] As sink the comparator reference takes the sink detection set.
// [RL12] Overvoltage on either channel pin disables the transmitter.
// [RL13] The receiver times edge gaps, a mid-cell edge meaning one and none meaning zero.
module usb_pd_bmc_phy
	import bmc_phy_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire tx_req_t    tx_req,
	output      logic       tx_ready,
	output      logic       tx_disabled,
	output      rx_bit_t    rx_bit,
	output      logic       bus_idle,
	input  wire logic       cfg_channel_pin_one_in,
	output      logic       cfg_channel_pin_one_out,
	output      logic       cfg_channel_pin_one_oe_n,
	input  wire logic       cfg_channel_pin_two_in,
	output      logic       cfg_channel_pin_two_out,
	output      logic       cfg_channel_pin_two_oe_n,
	input  wire logic       ovp_pin_one,
	input  wire logic       ovp_pin_two,
	input  wire logic       attached,
	input  wire logic       orient_pin_two,
	input  wire logic       role_source,
	input  wire logic [1:0] advertised_pullup_current,
	output      logic [2:0] detect_compare_reference
);

	top_state_t  s_reg;
	top_state_t  s_next;
	line_drive_t enc_line;
	logic        tx_abort;
	logic        rx_line;

	// Comparator reference for the present role
	function automatic logic [2:0] ref_select(input logic src, input logic [1:0] rp);
		if (!src) begin
			ref_select = REF_SINK;
		end else if (rp == RP_3P0) begin
			ref_select = REF_SRC_3P0;
		end else if (rp == RP_1P5) begin
			ref_select = REF_SRC_1P5;
		end else begin
			ref_select = REF_SRC_DEF;
		end
	endfunction

	// Transmit only when connected and free of overvoltage
	assign tx_abort = s_reg.tx_off;
	// Receiver watches only the mated pin [RL7]
	assign rx_line  = s_reg.orient ? s_reg.cc_s2[1] : s_reg.cc_s2[0];

	bmc_encoder u_encoder (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tx_req   (tx_req),
		.tx_abort (tx_abort),
		.tx_ready (tx_ready),
		.line     (enc_line)
	);

	bmc_decoder u_decoder (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.line_in  (rx_line),
		.rx_bit   (rx_bit),
		.bus_idle (bus_idle)
	);

	// Synchronisers, orientation hold and pin steering
	always_comb begin
		s_next        = s_reg;
		// Pins and comparator flags are asynchronous: two stages each
		s_next.cc_s1  = {cfg_channel_pin_two_in, cfg_channel_pin_one_in};
		s_next.cc_s2  = s_reg.cc_s1;
		s_next.ovp_s1 = {ovp_pin_two, ovp_pin_one};
		s_next.ovp_s2 = s_reg.ovp_s1;
		s_next.connected = attached;
		// Orientation is taken only while no connection stands [RL8]
		if (!s_reg.connected) begin
			s_next.orient = orient_pin_two;
		end
		s_next.tx_off = (|s_reg.ovp_s2) || !s_reg.connected;	// [RL12]
		// Drive only the mated pin; the other always floats [RL7] [RL6]
		s_next.pin_out  = '0;
		s_next.pin_oe_n = 2'h3;
		// Connection gate too, so the pin never moves while orientation is retaken
		if (enc_line.drive && !s_reg.tx_off && s_reg.connected) begin
			if (s_reg.orient) begin
				s_next.pin_out[1]  = enc_line.level;
				s_next.pin_oe_n[1] = 1'b0;
			end else begin
				s_next.pin_out[0]  = enc_line.level;
				s_next.pin_oe_n[0] = 1'b0;
			end
		end
		s_next.ref_sel = ref_select(role_source, advertised_pullup_current);	// [RL10] [RL11]
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_reg          <= '0;
			s_reg.pin_oe_n <= 2'h3;
			s_reg.tx_off   <= 1'b1;
			// Synchronisers start at the bias level: no false edge after reset
			s_reg.cc_s1    <= 2'h3;
			s_reg.cc_s2    <= 2'h3;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register
	assign cfg_channel_pin_one_out  = s_reg.pin_out[0];
	assign cfg_channel_pin_two_out  = s_reg.pin_out[1];
	assign cfg_channel_pin_one_oe_n = s_reg.pin_oe_n[0];
	assign cfg_channel_pin_two_oe_n = s_reg.pin_oe_n[1];
	assign detect_compare_reference = s_reg.ref_sel;
	assign tx_disabled              = s_reg.tx_off;

	a_one_pin_only: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL7]
		!(!cfg_channel_pin_one_oe_n && !cfg_channel_pin_two_oe_n))
		else $error("both channel pins driven");
	a_drive_follows_orient: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL7]
		!cfg_channel_pin_one_oe_n |-> !s_reg.orient)
		else $error("unmated pin driven");
	a_drive_pin_two: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL7]
		!cfg_channel_pin_two_oe_n |-> s_reg.orient)
		else $error("pin two driven while pin one is mated");
	a_float_out_low: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL6]
		!(cfg_channel_pin_one_oe_n && cfg_channel_pin_one_out)
		&& !(cfg_channel_pin_two_oe_n && cfg_channel_pin_two_out))
		else $error("floating pin carries a driven level");
	a_orient_hold: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL8]
		(s_reg.connected && $past(s_reg.connected)) |-> $stable(s_reg.orient))
		else $error("orientation changed during connection");
	// Blocked flag one cycle after the synced flag, pins float one cycle later
	a_ovp_cutoff: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL12]
		(|s_reg.ovp_s2) |=> tx_disabled
		##1 (cfg_channel_pin_one_oe_n && cfg_channel_pin_two_oe_n))
		else $error("driver still on after overvoltage");
	a_ref_sink: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL11]
		!role_source |=> detect_compare_reference == REF_SINK)
		else $error("sink role without sink thresholds");
	a_ref_source: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL10]
		(role_source && advertised_pullup_current == RP_3P0)
		|=> detect_compare_reference == REF_SRC_3P0)
		else $error("source threshold does not track pull-up level");
	a_ref_source_mid: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL10]
		(role_source && advertised_pullup_current == RP_1P5)
		|=> detect_compare_reference == REF_SRC_1P5)
		else $error("source threshold does not track middle pull-up level");

endmodule // usb_pd_bmc_phy

// ==== bmc_phy_pkg.sv ====
package bmc_phy_pkg;

	// Core clock rate and link timing, in their own units
	localparam int CLK_MHZ = 100;
	localparam int BIT_NS  = 3333;	// Nominal unit interval at 300 kbit/s
	localparam int IDLE_NS = 12000;	// No edge for this long means bus idle
	localparam int CW      = 12;

	// Cycle counts derived from the times above
	localparam logic [CW-1:0] UI_LAST   = CW'(BIT_NS * CLK_MHZ / 1000 - 1);
	localparam logic [CW-1:0] HALF_LAST = CW'(BIT_NS * CLK_MHZ / 2000 - 1);
	// Edge gaps below three quarters of a bit count as half-bit gaps
	localparam logic [CW-1:0] SHORT_MAX = CW'(BIT_NS * CLK_MHZ * 3 / 4000);
	// Idle time is a least time: round up
	localparam logic [CW-1:0] IDLE_CYC  = CW'((IDLE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CW-1:0] CNT_MAX   = 12'hfff;

	// Advertised pull-up current levels
	localparam logic [1:0] RP_DEFAULT = 2'h0;
	localparam logic [1:0] RP_1P5     = 2'h1;
	localparam logic [1:0] RP_3P0     = 2'h2;

	// Comparator reference selections
	localparam logic [2:0] REF_SINK    = 3'h0;
	localparam logic [2:0] REF_SRC_DEF = 3'h1;
	localparam logic [2:0] REF_SRC_1P5 = 3'h2;
	localparam logic [2:0] REF_SRC_3P0 = 3'h3;

	typedef enum logic [3:0] {
		ENC_IDLE = 4'h1,
		ENC_LEAD = 4'h2,
		ENC_BIT  = 4'h4,
		ENC_TAIL = 4'h8
	} enc_phase_t;

	typedef struct packed {
		logic valid;
		logic value;
		logic last;
	} tx_req_t;

	typedef struct packed {
		logic valid;
		logic value;
	} rx_bit_t;

	typedef struct packed {
		logic drive;
		logic level;
	} line_drive_t;

	typedef struct packed {
		enc_phase_t  phase;
		logic [CW-1:0] cnt;
		line_drive_t line;
		logic        cur_value;
		logic        cur_last;
		logic        ready;
	} enc_state_t;

	typedef struct packed {
		logic          prev;
		logic          active;
		logic          half_seen;
		logic          idle;
		logic [CW-1:0] cnt;
		rx_bit_t       rx;
	} dec_state_t;

	typedef struct packed {
		logic [1:0] cc_s1;
		logic [1:0] cc_s2;
		logic [1:0] ovp_s1;
		logic [1:0] ovp_s2;
		logic       connected;
		logic       orient;
		logic [1:0] pin_out;
		logic [1:0] pin_oe_n;
		logic [2:0] ref_sel;
		logic       tx_off;
	} top_state_t;

	// Saturating counter step
	function automatic logic [CW-1:0] cnt_inc(input logic [CW-1:0] c);
		cnt_inc = (c == CNT_MAX) ? c : c + CW'(1);
	endfunction

endpackage

// ==== bmc_encoder.sv ====
`timescale 1ns/100ps
module bmc_encoder
	import bmc_phy_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire tx_req_t     tx_req,
	input  wire logic        tx_abort,
	output      logic        tx_ready,
	output      line_drive_t line
);

	enc_state_t s_reg;
	enc_state_t s_next;
	logic       take;

	assign take     = tx_req.valid && s_reg.ready;
	assign tx_ready = s_reg.ready;
	assign line     = s_reg.line;

	// Bit timing and edge placement; no flat run beyond one cell [RL2]
	always_comb begin
		s_next     = s_reg;
		s_next.cnt = cnt_inc(s_reg.cnt);
		case (s_reg.phase)
			ENC_IDLE: begin
				s_next.cnt  = '0;
				s_next.line = '0;
				if (take) begin
					s_next.phase      = ENC_LEAD;
					s_next.line.drive = 1'b1;	// [RL6]
					s_next.line.level = 1'b0;	// Lead half-cell opens low [RL3]
					s_next.cur_value  = tx_req.value;
					s_next.cur_last   = tx_req.last;
				end
			end
			ENC_LEAD: begin
				if (s_reg.cnt == HALF_LAST) begin
					s_next.phase      = ENC_BIT;
					s_next.cnt        = '0;
					s_next.line.level = ~s_reg.line.level;	// First bit edge [RL1]
				end
			end
			ENC_BIT: begin
				// Mid-cell edge only for a one [RL1]
				if (s_reg.cnt == HALF_LAST && s_reg.cur_value) begin
					s_next.line.level = ~s_reg.line.level;
				end
				if (s_reg.cnt == UI_LAST) begin
					// Next cell edge, or the closing edge after the last bit [RL1] [RL5]
					s_next.line.level = ~s_reg.line.level;
					s_next.cnt        = '0;
					if (!s_reg.cur_last && take) begin
						s_next.cur_value = tx_req.value;
						s_next.cur_last  = tx_req.last;
					end else begin
						// Underrun closes the frame like a last bit
						s_next.phase = ENC_TAIL;
					end
				end
			end
			ENC_TAIL: begin
				// Hold the closing level half a cell, then let the bias return [RL6]
				if (s_reg.cnt == HALF_LAST) begin
					s_next.phase = ENC_IDLE;
					s_next.cnt   = '0;
					s_next.line  = '0;
				end
			end
			default: begin
				s_next.phase = ENC_IDLE;
				s_next.cnt   = '0;
				s_next.line  = '0;
			end
		endcase
		// Abort drops the driver at once, mid-bit if need be [RL12]
		if (tx_abort) begin
			s_next.phase = ENC_IDLE;
			s_next.cnt   = '0;
			s_next.line  = '0;
		end
		// Ready is set a cycle ahead so the handshake stays registered
		s_next.ready = !tx_abort && ((s_next.phase == ENC_IDLE) ||
			(s_next.phase == ENC_BIT && s_next.cnt == UI_LAST && !s_next.cur_last));
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_reg       <= '0;
			s_reg.phase <= ENC_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// Current flat run while driving, for the balance check
	logic [CW-1:0] run_reg;
	always_ff @(posedge core_clk) begin
		if (!rst_n || !s_reg.line.drive || s_reg.line.level != s_next.line.level) begin
			run_reg <= '0;
		end else begin
			run_reg <= cnt_inc(run_reg);
		end
	end

	a_lead_low: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL3]
		$rose(s_reg.line.drive) |-> !s_reg.line.level)
		else $error("driver did not open low");
	a_mid_edge_one: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL1]
		(s_reg.phase == ENC_BIT && s_reg.cnt == HALF_LAST && !tx_abort)
		|=> (s_reg.line.level != $past(s_reg.line.level)) == $past(s_reg.cur_value))
		else $error("mid-cell edge does not match bit value");
	a_closing_edge: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL5]
		(s_reg.phase == ENC_BIT && s_reg.cnt == UI_LAST && s_reg.cur_last && !tx_abort)
		|=> s_reg.phase == ENC_TAIL && s_reg.line.level != $past(s_reg.line.level))
		else $error("no closing edge after last bit");
	a_flat_run: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL2]
		run_reg <= UI_LAST)
		else $error("line held flat longer than one bit");
	a_release_idle: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL6]
		s_reg.phase == ENC_IDLE |-> !s_reg.line.drive)
		else $error("driver on while idle");

endmodule // bmc_encoder

// ==== bmc_decoder.sv ====
`timescale 1ns/100ps
module bmc_decoder
	import bmc_phy_pkg::*;
(
	input  wire logic    core_clk,
	input  wire logic    rst_n,
	input  wire logic    line_in,
	output      rx_bit_t rx_bit,
	output      logic    bus_idle
);

	dec_state_t s_reg;
	dec_state_t s_next;
	logic       edge_seen;

	assign edge_seen = line_in ^ s_reg.prev;
	assign rx_bit    = s_reg.rx;
	assign bus_idle  = s_reg.idle;

	// Gap timing between edges; a first edge only starts the clock
	always_comb begin
		s_next          = s_reg;
		s_next.prev     = line_in;
		s_next.rx.valid = 1'b0;
		s_next.cnt      = cnt_inc(s_reg.cnt);
		if (edge_seen) begin
			s_next.cnt    = '0;
			s_next.idle   = 1'b0;	// [RL9]
			s_next.active = 1'b1;
			if (s_reg.active) begin
				if (s_reg.cnt < SHORT_MAX) begin
					// Two half gaps make a one [RL13]
					if (s_reg.half_seen) begin
						s_next.rx.valid  = 1'b1;
						s_next.rx.value  = 1'b1;
						s_next.half_seen = 1'b0;
					end else begin
						s_next.half_seen = 1'b1;
					end
				end else begin
					// A full gap is a zero; a stray half is dropped [RL13]
					s_next.rx.valid  = 1'b1;
					s_next.rx.value  = 1'b0;
					s_next.half_seen = 1'b0;
				end
			end
		end else if (s_reg.cnt >= IDLE_CYC) begin
			// Quiet line: report idle and rearm for a fresh lock [RL9]
			s_next.idle      = 1'b1;
			s_next.active    = 1'b0;
			s_next.half_seen = 1'b0;
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_reg      <= '0;
			s_reg.idle <= 1'b1;
			s_reg.prev <= 1'b1;	// Bias level, so no false edge follows reset
		end else begin
			s_reg <= s_next;
		end
	end

	a_first_edge_mute: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL13]
		(edge_seen && !s_reg.active) |=> !s_reg.rx.valid)
		else $error("bit emitted on first edge");
	a_long_gap_zero: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL13]
		(edge_seen && s_reg.active && s_reg.cnt >= SHORT_MAX)
		|=> s_reg.rx.valid && !s_reg.rx.value)
		else $error("full gap not decoded as zero");
	a_half_pair_one: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL13]
		(edge_seen && s_reg.active && s_reg.cnt < SHORT_MAX && s_reg.half_seen)
		|=> s_reg.rx.valid && s_reg.rx.value)
		else $error("two half gaps not decoded as one");
	a_idle_timeout: assert property (@(posedge core_clk) disable iff (!rst_n)	// [RL9]
		(s_reg.cnt >= IDLE_CYC && !edge_seen) |=> s_reg.idle)
		else $error("idle not reported after quiet time");

endmodule // bmc_decoder

// ==== far_port_model.sv ====
`timescale 1ns/100ps
// Far port: drives coded frames onto the mated pin and floats it otherwise
module far_port_model (
	input  wire logic core_clk,
	output      logic drive_en,
	output      logic drive_level
);
	initial begin
		drive_en    = 1'b0;
		drive_level = 1'b1;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Call just after a rising edge; a full-cell lead keeps the start unambiguous
	task automatic send(input logic [15:0] bits, input int n);
		drive_en    <= 1'b1;
		drive_level <= 1'b0;	// Opens low, so that edge may be lost
		wait_cyc(333);
		for (int i = 0; i < n; i++) begin
			drive_level <= ~drive_level;	// Cell start edge
			wait_cyc(166);
			if (bits[i])
				drive_level <= ~drive_level;	// Mid-cell edge for a one
			wait_cyc(167);
		end
		drive_level <= ~drive_level;	// Closing edge lets the last bit be taken
		wait_cyc(166);
		drive_en    <= 1'b0;
		drive_level <= 1'b1;
	endtask
endmodule // far_port_model

// ==== usb_pd_bmc_phy_bench.sv ====
`timescale 1ns/100ps
module usb_pd_bmc_phy_bench import bmc_phy_pkg::*;;
	logic       core_clk;
	logic       rst_n;
	tx_req_t    tx_req;
	rx_bit_t    rx_bit;
	logic       tx_ready, tx_disabled, bus_idle;
	logic       p1_out, p1_oe_n, p2_out, p2_oe_n, ovp_pin_one, ovp_pin_two;
	logic       attached, orient_pin_two, role_source, far_on_two;
	logic [1:0] advertised_pullup_current;
	logic [2:0] detect_compare_reference;
	logic       far_en, far_lvl, line1, line2, mline, mline_q;
	logic       drove1, drove2, busy_seen;
	int         n_errors, check_count, cyc;
	int         edges[$];
	logic       rxq[$];

	// Pin level: local driver, then far port, else the bias pulls it high
	assign line1 = !p1_oe_n ? p1_out : (far_en && !far_on_two) ? far_lvl : 1'b1;
	assign line2 = !p2_oe_n ? p2_out : (far_en && far_on_two) ? far_lvl : 1'b1;
	assign mline = far_on_two ? line2 : line1;

	usb_pd_bmc_phy usb_pd_bmc_phy_i (.core_clk(core_clk), .rst_n(rst_n), .tx_req(tx_req),
		.tx_ready(tx_ready), .tx_disabled(tx_disabled), .rx_bit(rx_bit), .bus_idle(bus_idle),
		.cfg_channel_pin_one_in(line1), .cfg_channel_pin_one_out(p1_out),
		.cfg_channel_pin_one_oe_n(p1_oe_n), .cfg_channel_pin_two_in(line2),
		.cfg_channel_pin_two_out(p2_out), .cfg_channel_pin_two_oe_n(p2_oe_n),
		.ovp_pin_one(ovp_pin_one), .ovp_pin_two(ovp_pin_two), .attached(attached),
		.orient_pin_two(orient_pin_two), .role_source(role_source),
		.advertised_pullup_current(advertised_pullup_current),
		.detect_compare_reference(detect_compare_reference));

	far_port_model far_port_model_i (.core_clk(core_clk), .drive_en(far_en),
		.drive_level(far_lvl));

	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	task automatic end_sim();
		if (n_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Edge times on the mated pin, pin use, and received bits; cycle ceiling too
	always @(posedge core_clk) begin
		cyc     <= cyc + 1;
		mline_q <= mline;
		if (mline !== mline_q)
			edges.push_back(cyc);
		if (p1_oe_n === 1'b0)
			drove1 <= 1'b1;
		if (p2_oe_n === 1'b0)
			drove2 <= 1'b1;
		if (bus_idle === 1'b0 && (p1_oe_n === 1'b0 || p2_oe_n === 1'b0))
			busy_seen <= 1'b1;
		if (rx_bit.valid === 1'b1)
			rxq.push_back(rx_bit.value);
		if (cyc == 60000) begin
			n_errors++;
			end_sim();
		end
	end

	// Offer one bit and hold it until ready is seen; ends on the taking edge
	task automatic tx_bit(input logic v, input logic l);
		int k;
		tx_req <= {1'b1, v, l};
		k = 0;
		do begin
			@(negedge core_clk);
			k++;
		end while (tx_ready !== 1'b1 && k < 2000);
		@(posedge core_clk);
	endtask

	task automatic connect(input logic two);
		attached       <= 1'b0;
		orient_pin_two <= two;
		far_on_two     <= two;
		repeat (3) @(posedge core_clk);
		attached <= 1'b1;
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		chk(16'({tx_ready, tx_disabled}), 16'h0002);
		@(posedge core_clk);
	endtask

	// Send a frame, then decode the mated pin from edge gaps
	task automatic tx_frame(input logic [15:0] bits, input int n);
		int   i, g, mx;
		logic got[$];
		edges.delete();
		drove1    = 1'b0;
		drove2    = 1'b0;
		busy_seen = 1'b0;
		for (i = 0; i < n; i++)
			tx_bit(bits[i], i == n - 1);
		tx_req <= '0;
		repeat (600) @(posedge core_clk);
		@(negedge core_clk);
		chk(16'({p1_oe_n, p2_oe_n, tx_ready}), 16'h0007);
		chk(16'({drove1, drove2}), far_on_two ? 16'h0001 : 16'h0002);
		chk(16'(busy_seen), 16'h0001);
		chk(16'(edges.size() > 1 && edges[1] - edges[0] >= 160), 16'h0001);
		// The lead edge is skipped, as a far receiver may lose it
		mx = 0;
		i  = 1;
		while (i + 1 < edges.size() && got.size() < n) begin
			g = edges[i + 1] - edges[i];
			if (g > mx)
				mx = g;
			got.push_back(g < 250);
			i += (g < 250) ? 2 : 1;
		end
		chk(16'(got.size()), 16'(n));
		for (i = 0; i < got.size(); i++)
			chk(16'(got[i]), 16'(bits[i]));
		chk(16'(mx <= 340), 16'h0001);
		@(posedge core_clk);
	endtask

	// Far port sends; the lead cell may yield one extra leading zero
	task automatic rx_frame(input logic [15:0] bits, input int n);
		int i, s;
		// Let the receiver fall idle first, so the far lead edge starts a fresh lock
		repeat (1300) @(posedge core_clk);
		rxq.delete();
		far_port_model_i.send(bits, n);
		// Busy is checked before the idle time can run out after the last edge
		repeat (1000) @(posedge core_clk);
		@(negedge core_clk);
		chk(16'(bus_idle), 16'h0000);
		repeat (300) @(posedge core_clk);
		@(negedge core_clk);
		chk(16'(bus_idle), 16'h0001);
		s = rxq.size();
		chk(16'(s == n || s == n + 1), 16'h0001);
		for (i = 0; i < n && s >= n; i++)
			chk(16'(rxq[s - n + i]), 16'(bits[i]));
		@(posedge core_clk);
	endtask

	initial begin
		void'($urandom(37420));
		n_errors = 0;
		check_count = 0;
		cyc = 0;
		rst_n = 1'b0;
		tx_req = '0;
		ovp_pin_one = 1'b0;
		ovp_pin_two = 1'b0;
		attached = 1'b0;
		orient_pin_two = 1'b0;
		role_source = 1'b1;
		advertised_pullup_current = 2'h0;
		far_on_two = 1'b0;
		mline_q = 1'b1;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		chk(16'({p1_oe_n, p2_oe_n, tx_ready, tx_disabled, bus_idle}), 16'h001b);
		// Every role and current level, reserved code included
		for (int r = 0; r < 2; r++) begin
			for (int c = 0; c < 4; c++) begin
				@(posedge core_clk);
				role_source               <= r[0];
				advertised_pullup_current <= c[1:0];
				repeat (2) @(posedge core_clk);
				@(negedge core_clk);
				chk(16'(detect_compare_reference), 16'(r == 0 ? REF_SINK : c == 1 ? REF_SRC_1P5
					: c == 2 ? REF_SRC_3P0 : REF_SRC_DEF));
			end
		end
		@(posedge core_clk);
		connect(1'b0);
		// Overvoltage on each pin blocks sending while it lasts
		for (int p = 0; p < 2; p++) begin
			ovp_pin_one <= (p == 0);
			ovp_pin_two <= (p == 1);
			repeat (4) @(posedge core_clk);
			@(negedge core_clk);
			chk(16'({tx_ready, tx_disabled}), 16'h0001);
			@(posedge core_clk);
			ovp_pin_one <= 1'b0;
			ovp_pin_two <= 1'b0;
			repeat (5) @(posedge core_clk);
		end
		tx_frame(16'($urandom), 10);
		tx_frame(16'h0000, 8);
		tx_frame(16'hffff, 8);
		// Overvoltage during the lead half-cell floats the pin within a few cycles
		tx_bit(1'b1, 1'b1);
		tx_req <= '0;
		repeat (100) @(posedge core_clk);
		@(negedge core_clk);
		chk(16'({p1_oe_n, tx_disabled}), 16'h0000);
		@(posedge core_clk);
		ovp_pin_two <= 1'b1;
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		chk(16'({p1_oe_n, p2_oe_n, tx_disabled}), 16'h0007);
		@(posedge core_clk);
		ovp_pin_two <= 1'b0;
		repeat (600) @(posedge core_clk);
		rx_frame(16'($urandom), 10);
		// Orientation flip inside a connection must not move traffic
		orient_pin_two <= 1'b1;
		tx_frame(16'($urandom), 10);
		connect(1'b1);
		tx_frame(16'($urandom), 10);
		rx_frame(16'($urandom), 12);
		end_sim();
	end
endmodule // usb_pd_bmc_phy_bench
